// ===== hip_pkg.sv
package hip_pkg;

	// drive time base: clock rate and the 1 ms tick
	localparam int unsigned CLK_PERIOD_NS = 8;
	localparam int unsigned MS_NS         = 1000000;
	localparam int unsigned MS_CYCLES     = (MS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	// operating mode selection codes
	localparam logic [7:0] MODE_HOMING = 8'h06;
	localparam logic [7:0] MODE_INTERP = 8'h07;

	// control and status bit positions
	localparam int unsigned CTRL_GO_BIT    = 4;
	localparam int unsigned CTRL_HALT_BIT  = 8;
	localparam int unsigned ST_REACHED_BIT = 10;
	localparam int unsigned ST_ACTIVE_BIT  = 12;
	localparam int unsigned ST_ERROR_BIT   = 13;
	localparam int unsigned ST_REJECT_BIT  = 16;

	// register byte offsets, one aligned word each
	localparam logic [7:0] OFS_CTRL     = 8'h00;
	localparam logic [7:0] OFS_MODE     = 8'h04;
	localparam logic [7:0] OFS_STATUS   = 8'h08;
	localparam logic [7:0] OFS_METHOD   = 8'h0c;
	localparam logic [7:0] OFS_HOME_OFS = 8'h10;
	localparam logic [7:0] OFS_SPD_SW   = 8'h14;
	localparam logic [7:0] OFS_SPD_IDX  = 8'h18;
	localparam logic [7:0] OFS_HOM_ACC  = 8'h1c;
	localparam logic [7:0] OFS_BLK_CUR  = 8'h20;
	localparam logic [7:0] OFS_BLK_MS   = 8'h24;
	localparam logic [7:0] OFS_IP_MS    = 8'h28;
	localparam logic [7:0] OFS_BUF_EN   = 8'h2c;
	localparam logic [7:0] OFS_IP_TGT   = 8'h30;
	localparam logic [7:0] OFS_PROF_VEL = 8'h34;
	localparam logic [7:0] OFS_PROF_DEC = 8'h38;
	localparam logic [7:0] OFS_MAX_DEC  = 8'h3c;
	localparam logic [7:0] OFS_HALT_OPT = 8'h40;
	localparam logic [7:0] OFS_FE_WIN   = 8'h44;
	localparam logic [7:0] OFS_FE_MS    = 8'h48;
	localparam logic [7:0] OFS_POS_ACT  = 8'h4c;
	localparam logic [7:0] OFS_POS_DEM  = 8'h50;
	localparam logic [7:0] OFS_IP_ACC   = 8'h54;

	// reset values
	localparam logic [31:0] RST_ZERO      = 32'h0000_0000;
	localparam logic [31:0] RST_PERIOD_MS = 32'h0000_0001;
	localparam logic [31:0] RST_FE_WIN    = 32'h0000_0100;
	localparam logic [31:0] RST_FE_MS     = 32'h0000_000a;

	// method number landmarks
	localparam logic [7:0] M_IDX_LAST   = 8'h0e;
	localparam logic [7:0] M_NOIDX_LO   = 8'h11;
	localparam logic [7:0] M_NOIDX_HI   = 8'h1e;
	localparam logic [7:0] M_NOIDX_SHFT = 8'h10;
	localparam logic [7:0] M_NEXT_NEG   = 8'h21;
	localparam logic [7:0] M_NEXT_POS   = 8'h22;
	localparam logic [7:0] M_HERE       = 8'h23;

	// what the search references to
	typedef enum logic [2:0] {K_LIMIT, K_HOME_L, K_HOME_R, K_INDEX, K_HERE} hip_kind_t;

	typedef struct packed {
		logic      valid;
		logic      block;
		logic      use_idx;
		hip_kind_t kind;
		logic      lim_pos;
		logic      lim_neg;
		logic      dir_pos;
	} hip_meth_t;

	// decode a signed method number into travel profile and reference kind
	function automatic hip_meth_t hip_decode(input logic [7:0] m);
		hip_meth_t  d;
		logic [7:0] a;
		logic [7:0] b;
		d = '0;
		a = m[7] ? 8'(-m) : m;
		b = (a >= M_NOIDX_LO && a <= M_NOIDX_HI) ? 8'(a - M_NOIDX_SHFT) : a;
		d.block   = m[7];
		d.use_idx = (a <= M_IDX_LAST) || (a == M_NEXT_NEG) || (a == M_NEXT_POS);
		if (m[7])
			d.valid = (a <= M_NOIDX_HI) && (b inside {8'h01, 8'h02, [8'h07:8'h0e]});
		else
			d.valid = a inside {[8'h01:M_IDX_LAST], [M_NOIDX_LO:M_NOIDX_HI], [M_NEXT_NEG:M_HERE]};
		case (b)
			8'h01, 8'h02: d.kind = K_LIMIT;
			8'h03, 8'h04, 8'h07, 8'h08, 8'h0b, 8'h0c: d.kind = K_HOME_L;
			8'h05, 8'h06, 8'h09, 8'h0a, 8'h0d, 8'h0e: d.kind = K_HOME_R;
			M_NEXT_NEG, M_NEXT_POS: d.kind = K_INDEX;
			default: d.kind = K_HERE;
		endcase
		d.dir_pos = (b == 8'h02) || (b == M_NEXT_POS);
		d.lim_pos = b inside {[8'h07:8'h0a]};
		d.lim_neg = b inside {[8'h0b:8'h0e]};
		return d;
	endfunction : hip_decode

	// byte-lane merge for wishbone writes
	function automatic logic [31:0] hip_merge(input logic [31:0] old_v, input logic [31:0] new_v,
		input logic [3:0] sel);
		logic [31:0] r;
		r = old_v;
		for (int i = 0; i < 4; i++)
			if (sel[i])
				r[i*8 +: 8] = new_v[i*8 +: 8];
		return r;
	endfunction : hip_merge

endpackage : hip_pkg

// ===== hip_sync.sv
// two-flop synchroniser bank for pin inputs
module hip_sync #(
	parameter int unsigned W = 4
) (
	// clock and reset
	input  wire logic         clk_i,
	input  wire logic         rst_i,
	// asynchronous in, synchronised out
	input  wire logic [W-1:0] d_i,
	output logic      [W-1:0] q_o
);

	logic [W-1:0] meta_r;

	// one chain per bit; the first stage feeds only the second
	for (genvar g = 0; g < W; g++)
	begin : g_bit
		always_ff @(posedge clk_i)
		begin
			if (rst_i)
			begin
				meta_r[g] <= 1'b0;
				q_o[g]    <= 1'b0;
			end
			else
			begin
				meta_r[g] <= d_i[g];
				q_o[g]    <= meta_r[g];
			end
		end
	end

endmodule : hip_sync

// ===== hip_axis_ctrl.sv
// Behaviour
// - control bit 4 starts, clearing aborts search
// - status bits 13,12,10 encode search progress
// - bit 12 set after the latest search completed
// - bit 12 cleared while searching, on error
// - home offset placed between zero and reference
// - switch speed, then index speed
// - block is current over threshold, then dwell
// - index used by 1-14,33,34; not 17-30
// - negative method searches mechanical block instead
// - block search only in closed loop
// - block methods are -1,-2,-7..-14,-17,-18,-23..-30
// - 33/34 next index; 35 present position
// - method 35 runs without operation enabled
// - method 1 negative limit, 2 positive limit
// - 3/4 left edge, 5/6 right edge
// - 7-10 positive limit, 11-14 negative limit
// - interpolation runs only while bit 4 set
// - halt bit ramps down or brakes to standstill
// - bit 10 reached target, or halted standstill
// - bit 12 shows interpolation running
// - bit 13 following error after window timeout
// - linear path to target over period
// - sync paces segments once network operational
//
// Design decisions made here: the Wishbone interface to the registers and the address map.
module hip_axis_ctrl #(
	parameter int unsigned MS_CYCLES = hip_pkg::MS_CYCLES
) (
	// clock and reset
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	// wishbone classic slave
	input  wire logic        wb_cyc_i,
	input  wire logic        wb_stb_i,
	input  wire logic        wb_we_i,
	input  wire logic [7:0]  wb_adr_i,
	input  wire logic [3:0]  wb_sel_i,
	input  wire logic [31:0] wb_dat_i,
	output logic      [31:0] wb_dat_o,
	output logic             wb_ack_o,
	// switch and encoder pins, asynchronous
	input  wire logic        lim_neg_i,
	input  wire logic        lim_pos_i,
	input  wire logic        home_sw_i,
	input  wire logic        index_i,
	// drive-internal signals on this clock
	input  wire logic [31:0] pos_raw_i,
	input  wire logic [31:0] vel_act_i,
	input  wire logic [15:0] cur_act_i,
	input  wire logic        closed_loop_i,
	input  wire logic        op_enabled_i,
	input  wire logic        sync_i,
	input  wire logic        nmt_oper_i,
	// motion outputs
	output logic      [31:0] vel_cmd_o,
	output logic      [31:0] pos_demand_o,
	output logic      [31:0] pos_actual_o,
	output logic      [31:0] status_o
);

	if (MS_CYCLES < 2)
	begin : g_bad_ms
		$error("MS_CYCLES must be at least 2");
	end

	typedef enum {H_IDLE, H_SEEK, H_BLOCK, H_INDEX, H_DONE, H_ERR} hip_hstate_t;

	logic [31:0] ctrl_r, mode_r, method_r, home_ofs_r, spd_sw_r, spd_idx_r, hom_acc_r;
	logic [31:0] blk_cur_r, blk_ms_r, ip_ms_r, buf_en_r, ip_tgt_r, prof_vel_r, prof_dec_r;
	logic [31:0] max_dec_r, halt_opt_r, fe_win_r, fe_ms_r, ip_acc_r, rd_nxt;
	logic [31:0] ms_cnt_r, zero_r, vel_r, vel_tgt, vel_rate, demand_r, seg_end_r, diff_r;
	logic [31:0] seg_ms_r, budget_r, blk_cnt_r, fe_cnt_r, fe_dev, status_nxt;
	logic [33:0] rem_r;
	logic [3:0]  pins_s;
	logic        ack_r, wr, ms_tick, go, halt, hom_mode, ip_mode, ip_run, sync_ok;
	logic        go_d_r, idx_d_r, home_d_r, homed_r, reject_r, tgt_new_r, fe_r, dir_r;
	logic        lim_n, lim_p, home_s, idx_s, idx_rise, block_hit, lim_here, home_edge;
	logic        edge_ok, step_up, step_dn, tgt_wr;
	hip_hstate_t hst_r;
	hip_pkg::hip_meth_t meth_r, meth_new;

	hip_sync #(
		.W   (4)
	) u_sync (
		.clk_i (clk_i),
		.rst_i (rst_i),
		.d_i   ({index_i, home_sw_i, lim_pos_i, lim_neg_i}),
		.q_o   (pins_s)
	);

	assign {idx_s, home_s, lim_p, lim_n} = pins_s;
	assign go       = ctrl_r[hip_pkg::CTRL_GO_BIT];
	assign halt     = ctrl_r[hip_pkg::CTRL_HALT_BIT];
	assign hom_mode = mode_r[7:0] == hip_pkg::MODE_HOMING;
	assign ip_mode  = mode_r[7:0] == hip_pkg::MODE_INTERP;
	assign ip_run   = ip_mode && go && op_enabled_i;
	assign sync_ok  = sync_i && nmt_oper_i && ip_run;
	assign meth_new = hip_pkg::hip_decode(method_r[7:0]);
	assign idx_rise = idx_s && !idx_d_r;
	assign block_hit = cur_act_i > blk_cur_r[15:0];
	assign lim_here = dir_r ? lim_p : lim_n;
	assign home_edge = home_s != home_d_r;
	// moving positive a rising home level is the left edge, moving negative it is the right
	assign edge_ok  = home_edge && ((dir_r == home_s) == (meth_r.kind == hip_pkg::K_HOME_L));
	assign pos_actual_o = pos_raw_i - zero_r;
	assign pos_demand_o = demand_r;
	assign vel_cmd_o    = vel_r;
	assign status_o     = status_nxt;

	// classic wishbone: ack one cycle after the strobe, writes land on the ack edge
	assign wr       = wb_cyc_i && wb_stb_i && wb_we_i && ack_r;
	assign wb_ack_o = ack_r;
	assign tgt_wr   = wr && (wb_adr_i == hip_pkg::OFS_IP_TGT) && buf_en_r[0];

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			ack_r    <= 1'b0;
			wb_dat_o <= hip_pkg::RST_ZERO;
		end
		else
		begin
			ack_r    <= wb_cyc_i && wb_stb_i && !ack_r;
			wb_dat_o <= rd_nxt;
		end
	end

	// read decode; unmapped words answer with zero
	always_comb
	begin
		case ({wb_adr_i[7:2], 2'b00})
			hip_pkg::OFS_CTRL:     rd_nxt = ctrl_r;
			hip_pkg::OFS_MODE:     rd_nxt = mode_r;
			hip_pkg::OFS_STATUS:   rd_nxt = status_nxt;
			hip_pkg::OFS_METHOD:   rd_nxt = method_r;
			hip_pkg::OFS_HOME_OFS: rd_nxt = home_ofs_r;
			hip_pkg::OFS_SPD_SW:   rd_nxt = spd_sw_r;
			hip_pkg::OFS_SPD_IDX:  rd_nxt = spd_idx_r;
			hip_pkg::OFS_HOM_ACC:  rd_nxt = hom_acc_r;
			hip_pkg::OFS_BLK_CUR:  rd_nxt = blk_cur_r;
			hip_pkg::OFS_BLK_MS:   rd_nxt = blk_ms_r;
			hip_pkg::OFS_IP_MS:    rd_nxt = ip_ms_r;
			hip_pkg::OFS_BUF_EN:   rd_nxt = buf_en_r;
			hip_pkg::OFS_IP_TGT:   rd_nxt = ip_tgt_r;
			hip_pkg::OFS_PROF_VEL: rd_nxt = prof_vel_r;
			hip_pkg::OFS_PROF_DEC: rd_nxt = prof_dec_r;
			hip_pkg::OFS_MAX_DEC:  rd_nxt = max_dec_r;
			hip_pkg::OFS_HALT_OPT: rd_nxt = halt_opt_r;
			hip_pkg::OFS_FE_WIN:   rd_nxt = fe_win_r;
			hip_pkg::OFS_FE_MS:    rd_nxt = fe_ms_r;
			hip_pkg::OFS_POS_ACT:  rd_nxt = pos_actual_o;
			hip_pkg::OFS_POS_DEM:  rd_nxt = demand_r;
			hip_pkg::OFS_IP_ACC:   rd_nxt = ip_acc_r;
			default:               rd_nxt = hip_pkg::RST_ZERO;
		endcase
	end

	// software-written configuration
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			{ctrl_r, mode_r, method_r, home_ofs_r, spd_sw_r, spd_idx_r} <= {6{hip_pkg::RST_ZERO}};
			{hom_acc_r, blk_cur_r, blk_ms_r, buf_en_r, ip_tgt_r} <= {5{hip_pkg::RST_ZERO}};
			{prof_vel_r, prof_dec_r, max_dec_r, halt_opt_r, ip_acc_r} <= {5{hip_pkg::RST_ZERO}};
			ip_ms_r  <= hip_pkg::RST_PERIOD_MS;
			fe_win_r <= hip_pkg::RST_FE_WIN;
			fe_ms_r  <= hip_pkg::RST_FE_MS;
		end
		else if (wr)
		begin
			case (wb_adr_i)
				hip_pkg::OFS_CTRL:     ctrl_r     <= hip_pkg::hip_merge(ctrl_r, wb_dat_i, wb_sel_i);
				hip_pkg::OFS_MODE:     mode_r     <= hip_pkg::hip_merge(mode_r, wb_dat_i, wb_sel_i);
				hip_pkg::OFS_METHOD:   method_r   <= hip_pkg::hip_merge(method_r, wb_dat_i, wb_sel_i);
				hip_pkg::OFS_HOME_OFS: home_ofs_r <= hip_pkg::hip_merge(home_ofs_r, wb_dat_i, wb_sel_i);
				hip_pkg::OFS_SPD_SW:   spd_sw_r   <= hip_pkg::hip_merge(spd_sw_r, wb_dat_i, wb_sel_i);
				hip_pkg::OFS_SPD_IDX:  spd_idx_r  <= hip_pkg::hip_merge(spd_idx_r, wb_dat_i, wb_sel_i);
				hip_pkg::OFS_HOM_ACC:  hom_acc_r  <= hip_pkg::hip_merge(hom_acc_r, wb_dat_i, wb_sel_i);
				hip_pkg::OFS_BLK_CUR:  blk_cur_r  <= hip_pkg::hip_merge(blk_cur_r, wb_dat_i, wb_sel_i);
				hip_pkg::OFS_BLK_MS:   blk_ms_r   <= hip_pkg::hip_merge(blk_ms_r, wb_dat_i, wb_sel_i);
				hip_pkg::OFS_IP_MS:    ip_ms_r    <= hip_pkg::hip_merge(ip_ms_r, wb_dat_i, wb_sel_i);
				hip_pkg::OFS_BUF_EN:   buf_en_r   <= hip_pkg::hip_merge(buf_en_r, wb_dat_i, wb_sel_i);
				hip_pkg::OFS_IP_TGT:   if (buf_en_r[0])
					ip_tgt_r <= hip_pkg::hip_merge(ip_tgt_r, wb_dat_i, wb_sel_i);
				hip_pkg::OFS_PROF_VEL: prof_vel_r <= hip_pkg::hip_merge(prof_vel_r, wb_dat_i, wb_sel_i);
				hip_pkg::OFS_PROF_DEC: prof_dec_r <= hip_pkg::hip_merge(prof_dec_r, wb_dat_i, wb_sel_i);
				hip_pkg::OFS_MAX_DEC:  max_dec_r  <= hip_pkg::hip_merge(max_dec_r, wb_dat_i, wb_sel_i);
				hip_pkg::OFS_HALT_OPT: halt_opt_r <= hip_pkg::hip_merge(halt_opt_r, wb_dat_i, wb_sel_i);
				hip_pkg::OFS_FE_WIN:   fe_win_r   <= hip_pkg::hip_merge(fe_win_r, wb_dat_i, wb_sel_i);
				hip_pkg::OFS_FE_MS:    fe_ms_r    <= hip_pkg::hip_merge(fe_ms_r, wb_dat_i, wb_sel_i);
				hip_pkg::OFS_IP_ACC:   ip_acc_r   <= hip_pkg::hip_merge(ip_acc_r, wb_dat_i, wb_sel_i);
				default: ;
			endcase
		end
	end

	// 1 ms time base and edge history
	assign ms_tick = ms_cnt_r == 32'(MS_CYCLES - 1);
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			ms_cnt_r <= hip_pkg::RST_ZERO;
			{go_d_r, idx_d_r, home_d_r} <= 3'h0;
		end
		else
		begin
			ms_cnt_r <= ms_tick ? hip_pkg::RST_ZERO : ms_cnt_r + 32'h1;
			{go_d_r, idx_d_r, home_d_r} <= {go, idx_s, home_s};
		end
	end

	// reference search sequencer
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			hst_r     <= H_IDLE;
			meth_r    <= '0;
			dir_r     <= 1'b0;
			homed_r   <= 1'b0;
			reject_r  <= 1'b0;
			zero_r    <= hip_pkg::RST_ZERO;
			blk_cnt_r <= hip_pkg::RST_ZERO;
		end
		else if (hst_r != H_IDLE && (!go || !hom_mode))
			hst_r <= H_IDLE;
		else
		begin
			case (hst_r)
				H_IDLE:
					if (hom_mode && go && !go_d_r)
					begin
						meth_r <= meth_new;
						if (!meth_new.valid || (meth_new.block && !closed_loop_i))
							reject_r <= 1'b1;
						else if (meth_new.kind == hip_pkg::K_HERE)
						begin
							reject_r <= 1'b0;
							zero_r   <= pos_raw_i - home_ofs_r;
							homed_r  <= 1'b1;
							hst_r    <= H_DONE;
						end
						else if (!op_enabled_i)
							reject_r <= 1'b1;
						else
						begin
							reject_r <= 1'b0;
							homed_r  <= 1'b0;
							case (meth_new.kind)
								hip_pkg::K_HOME_L: dir_r <= !home_s;
								hip_pkg::K_HOME_R: dir_r <= home_s;
								default:           dir_r <= meth_new.dir_pos;
							endcase
							hst_r <= (meth_new.kind == hip_pkg::K_INDEX) ? H_INDEX : H_SEEK;
						end
					end
				H_SEEK:
					if (!op_enabled_i)
						hst_r <= H_ERR;
					else if (meth_r.kind == hip_pkg::K_LIMIT)
					begin
						if (meth_r.block ? block_hit : lim_here)
						begin
							blk_cnt_r <= hip_pkg::RST_ZERO;
							dir_r     <= !dir_r;                  // index lies back off the stop
							hst_r     <= meth_r.block ? H_BLOCK : (meth_r.use_idx ? H_INDEX : H_DONE);
						end
					end
					else if (edge_ok)
						hst_r <= meth_r.use_idx ? H_INDEX : H_DONE;
					else if (meth_r.block ? block_hit : lim_here)
					begin
						// reverse at the considered stop, any other stop is an error
						if ((dir_r && meth_r.lim_pos) || (!dir_r && meth_r.lim_neg))
							dir_r <= !dir_r;
						else
							hst_r <= H_ERR;
					end
				H_BLOCK:
					if (ms_tick)
					begin
						blk_cnt_r <= blk_cnt_r + 32'h1;
						if (blk_cnt_r + 32'h1 >= blk_ms_r)
							hst_r <= meth_r.use_idx ? H_INDEX : H_DONE;
					end
				H_INDEX:
					if (!op_enabled_i || (!meth_r.block && lim_here))
						hst_r <= H_ERR;
					else if (idx_rise)
						hst_r <= H_DONE;
				default: ;
			endcase
			if (hst_r != H_DONE && hst_r != H_ERR && hst_r != H_IDLE)
			begin
				if (hst_r == H_INDEX && idx_rise && op_enabled_i)
				begin
					zero_r  <= pos_raw_i - home_ofs_r;
					homed_r <= 1'b1;
				end
				else if (hst_r != H_INDEX && !meth_r.use_idx && edge_ok && meth_r.kind != hip_pkg::K_LIMIT)
				begin
					zero_r  <= pos_raw_i - home_ofs_r;
					homed_r <= 1'b1;
				end
				else if (hst_r == H_SEEK && !meth_r.use_idx && !meth_r.block && lim_here
					&& meth_r.kind == hip_pkg::K_LIMIT)
				begin
					zero_r  <= pos_raw_i - home_ofs_r;
					homed_r <= 1'b1;
				end
				else if (hst_r == H_BLOCK && !meth_r.use_idx && ms_tick && blk_cnt_r + 32'h1 >= blk_ms_r)
				begin
					zero_r  <= pos_raw_i - home_ofs_r;
					homed_r <= 1'b1;
				end
				if (!op_enabled_i)
					homed_r <= 1'b0;
			end
			if (hst_r == H_ERR)
				homed_r <= 1'b0;
		end
	end

	// speed target and ramp rate for the active mode
	always_comb
	begin
		vel_tgt  = hip_pkg::RST_ZERO;
		vel_rate = hom_acc_r;
		if (hom_mode && (hst_r == H_SEEK || hst_r == H_BLOCK))
			vel_tgt = dir_r ? spd_sw_r : 32'(-spd_sw_r);
		else if (hom_mode && hst_r == H_INDEX)
			vel_tgt = dir_r ? spd_idx_r : 32'(-spd_idx_r);
		else if (ip_mode)
		begin
			vel_tgt  = (ip_run && !halt) ? prof_vel_r : hip_pkg::RST_ZERO;
			vel_rate = (ip_run && !halt) ? ip_acc_r : ((halt_opt_r == hip_pkg::RST_ZERO) ?
				prof_dec_r : max_dec_r);
		end
	end

	// velocity ramp, one rate step per millisecond
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			vel_r <= hip_pkg::RST_ZERO;
		else if (ms_tick)
		begin
			if ($signed(vel_r) < $signed(vel_tgt))
				vel_r <= ($signed(vel_tgt - vel_r) > $signed(vel_rate)) ? vel_r + vel_rate : vel_tgt;
			else
				vel_r <= ($signed(vel_r - vel_tgt) > $signed(vel_rate)) ? vel_r - vel_rate : vel_tgt;
		end
	end

	// linear interpolation: the remainder gains the segment length every ms and
	// is drained one count per clock, so a segment can move at most MS_CYCLES-1 counts per ms
	assign step_up = !ms_tick && budget_r != 32'h0 && $signed(rem_r) >= $signed({2'b00, ip_ms_r});
	assign step_dn = !ms_tick && budget_r != 32'h0 && $signed(rem_r) <= -$signed({2'b00, ip_ms_r});
	always_ff @(posedge clk_i)
	begin
		if (rst_i || !ip_run)
		begin
			demand_r  <= rst_i ? hip_pkg::RST_ZERO : pos_actual_o;
			seg_end_r <= rst_i ? hip_pkg::RST_ZERO : pos_actual_o;
			diff_r    <= hip_pkg::RST_ZERO;
			seg_ms_r  <= hip_pkg::RST_ZERO;
			rem_r     <= 34'h0;
			budget_r  <= hip_pkg::RST_ZERO;
		end
		else
		begin
			if (sync_ok)
			begin
				seg_end_r <= ip_tgt_r;
				diff_r    <= ip_tgt_r - seg_end_r;
				seg_ms_r  <= hip_pkg::RST_ZERO;
			end
			if (ms_tick)
			begin
				budget_r <= vel_r[31] ? 32'(-vel_r) : vel_r;      // speed cap follows the ramp
				if (seg_ms_r < ip_ms_r && !sync_ok)
				begin
					rem_r    <= rem_r + {{2{diff_r[31]}}, diff_r};
					seg_ms_r <= seg_ms_r + 32'h1;
				end
			end
			else if (step_up)
			begin
				rem_r    <= rem_r - {2'b00, ip_ms_r};
				demand_r <= demand_r + 32'h1;
				budget_r <= budget_r - 32'h1;
			end
			else if (step_dn)
			begin
				rem_r    <= rem_r + {2'b00, ip_ms_r};
				demand_r <= demand_r - 32'h1;
				budget_r <= budget_r - 32'h1;
			end
		end
	end

	// new-target flag: a write in the consuming cycle keeps it set
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			tgt_new_r <= 1'b0;
		else if (tgt_wr)
			tgt_new_r <= 1'b1;
		else if (sync_ok)
			tgt_new_r <= 1'b0;
	end

	// following error watch, closed loop only
	assign fe_dev = demand_r - pos_actual_o;
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			fe_cnt_r <= hip_pkg::RST_ZERO;
			fe_r     <= 1'b0;
		end
		else if (closed_loop_i && ip_run && ((fe_dev[31] ? 32'(-fe_dev) : fe_dev) > fe_win_r))
		begin
			if (ms_tick && fe_cnt_r <= fe_ms_r)
				fe_cnt_r <= fe_cnt_r + 32'h1;
			if (fe_cnt_r > fe_ms_r)
				fe_r <= 1'b1;
		end
		else
		begin
			fe_cnt_r <= hip_pkg::RST_ZERO;
			fe_r     <= 1'b0;
		end
	end

	// status word for the active mode
	always_comb
	begin
		status_nxt = hip_pkg::RST_ZERO;
		status_nxt[hip_pkg::ST_REJECT_BIT] = reject_r;
		if (hom_mode)
		begin
			case (hst_r)
				H_IDLE:
				begin
					status_nxt[hip_pkg::ST_ACTIVE_BIT]  = homed_r;
					status_nxt[hip_pkg::ST_REACHED_BIT] = !homed_r;
				end
				H_DONE:
				begin
					status_nxt[hip_pkg::ST_ACTIVE_BIT]  = homed_r;
					status_nxt[hip_pkg::ST_REACHED_BIT] = vel_r == hip_pkg::RST_ZERO;
				end
				H_ERR:
				begin
					status_nxt[hip_pkg::ST_ERROR_BIT]   = 1'b1;
					status_nxt[hip_pkg::ST_REACHED_BIT] = vel_act_i == hip_pkg::RST_ZERO;
				end
				default: ;
			endcase
		end
		else if (ip_mode)
		begin
			status_nxt[hip_pkg::ST_ACTIVE_BIT] = ip_run;
			status_nxt[hip_pkg::ST_ERROR_BIT]  = fe_r;
			status_nxt[hip_pkg::ST_REACHED_BIT] = halt ? (vel_r == hip_pkg::RST_ZERO) :
				(demand_r == ip_tgt_r && !tgt_new_r);
		end
	end

endmodule : hip_axis_ctrl

// ===== hip_plant.sv
// motor, switches and fieldbus timing seen by the axis controller
module hip_plant (
	// clock and reset
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	// speed command in, shaft position and pins out
	input  wire logic [31:0] vel_cmd_i,
	output logic      [31:0] pos_o,
	output logic             lim_neg_o,
	output logic             index_o,
	output logic             sync_o
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [7:0] cnt_r;
	// one count per clock in the commanded direction keeps travel short
	always_ff @(posedge clk_i)
	begin
		pos_o <= rst_i ? 32'h0 : pos_o + (vel_cmd_i[31] ? 32'hffffffff : {31'h0, |vel_cmd_i});
		cnt_r <= rst_i ? 8'h00 : cnt_r + 8'h01;
	end
	// limit switch below -200, an index mark every 32 counts
	assign lim_neg_o = $signed(pos_o) < -32'sd200;
	assign index_o = pos_o[4:0] == 5'h00;
	assign sync_o = cnt_r == 8'hff;
endmodule : hip_plant

// ===== hip_props.sv
module hip_props (
	input wire logic        clk_i,
	input wire logic        rst_i,
	input wire logic        wb_cyc_i,
	input wire logic        wb_stb_i,
	input wire logic        wb_we_i,
	input wire logic [7:0]  wb_adr_i,
	input wire logic [31:0] wb_dat_o,
	input wire logic        wb_ack_o,
	input wire logic [31:0] vel_cmd_o,
	input wire logic [31:0] pos_actual_o,
	input wire logic [31:0] status_o
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	logic rq;
	logic rd;
	// a fresh request is one not yet answered
	assign rq = wb_cyc_i && wb_stb_i && !wb_ack_o;
	assign rd = rq && !wb_we_i;
	property p_ack_one; wb_ack_o |=> !wb_ack_o; endproperty
	a_ack_one: assert property (p_ack_one) else $error("ack held");
	property p_ack_rq; rq |=> wb_ack_o; endproperty
	a_ack_rq: assert property (p_ack_rq) else $error("ack late");
	property p_ack_no; !rq |=> !wb_ack_o; endproperty
	a_ack_no: assert property (p_ack_no) else $error("stray ack");
	property p_ack_cyc; wb_ack_o |-> wb_cyc_i && wb_stb_i; endproperty
	a_ack_cyc: assert property (p_ack_cyc) else $error("ack outside cycle");
	property p_rst; $fell(rst_i) |-> !wb_ack_o && vel_cmd_o == 32'h0 && status_o == 32'h0; endproperty
	a_rst: assert property (p_rst) else $error("not idle after reset");
	property p_unmap; rd && wb_adr_i > 8'h57 |=> wb_dat_o == 32'h0; endproperty
	a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
	property p_st_rd; rd && wb_adr_i == 8'h08 |=> wb_dat_o == $past(status_o); endproperty
	a_st_rd: assert property (p_st_rd) else $error("status read differs");
	property p_pa_rd; rd && wb_adr_i == 8'h4c |=> wb_dat_o == $past(pos_actual_o); endproperty
	a_pa_rd: assert property (p_pa_rd) else $error("position read differs");
endmodule : hip_props
bind hip_axis_ctrl hip_props u_props (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
	.wb_dat_o, .wb_ack_o, .vel_cmd_o, .pos_actual_o, .status_o);

// ===== testbench.sv
`define CK(g, e) begin checks++; if ((g) !== (e)) begin mismatches++; $display("BAD %0t got %h want %h", $time, g, e); end end
module testbench;
	timeunit 1ns;
	timeprecision 1ns;
	logic             clk_i = 1'b0;
	logic             rst_i, req, we, op_en, nmt, cl;
	logic [7:0]       adr;
	logic [31:0]      dat, rd, t;
	wire logic [31:0] wb_dat_o, vel_cmd_o, status_o, pos;
	wire logic        wb_ack_o, lim, idx, syn;
	int               checks = 0, mismatches = 0;
	logic [7:0]       bad [7] = '{8'h1f, 8'h23, 8'h0f, 8'h23, 8'hfd, 8'h23, 8'hff};
	// 125 MHz clock
	always #4 clk_i = ~clk_i;
	hip_axis_ctrl #(.MS_CYCLES(20)) dut (.clk_i, .rst_i, .wb_cyc_i(req), .wb_stb_i(req),
		.wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(dat), .wb_dat_o, .wb_ack_o,
		.lim_neg_i(lim), .lim_pos_i(1'b0), .home_sw_i(1'b0), .index_i(idx), .pos_raw_i(pos),
		.vel_act_i(vel_cmd_o), .cur_act_i(16'h0), .closed_loop_i(cl), .op_enabled_i(op_en),
		.sync_i(syn), .nmt_oper_i(nmt), .vel_cmd_o, .pos_demand_o(), .pos_actual_o(), .status_o);
	hip_plant u_plant (.clk_i, .rst_i, .vel_cmd_i(vel_cmd_o), .pos_o(pos), .lim_neg_o(lim),
		.index_o(idx), .sync_o(syn));
	// one classic cycle, released at the ack edge
	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clk_i);
		req <= 1'b1;
		we <= w;
		adr <= a;
		dat <= d;
		do @(posedge clk_i); while (wb_ack_o !== 1'b1 && ++n < 50);
		if (n >= 50) mismatches++;
		rd = wb_dat_o;
		req <= 1'b0;
	endtask : wb
	task automatic rc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
		wb(1'b0, a, 32'h0);
		`CK(rd & m, e)
	endtask : rc
	// bounded wait for a status bit
	task automatic wt(input int b);
		for (int n = 0; n < 20000 && status_o[b] !== 1'b1; n++) @(posedge clk_i);
	endtask : wt
	task automatic close_out;
		$display("checks %0d mismatches %0d", checks, mismatches);
		if (mismatches == 0 && checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : close_out
	initial
	begin
		#400000;
		mismatches++;
		close_out();
	end
	initial
	begin
		rst_i = 1'b1;
		{req, we, op_en, nmt, cl, adr, dat} = '0;
		repeat (6) @(posedge clk_i);
		rst_i <= 1'b0;
		rc(8'h28, '1, 32'h1);
		rc(8'h44, '1, 32'h100);
		rc(8'h58, '1, 32'h0);
		// present position reference while not enabled
		wb(1'b1, 8'h10, 32'h10);
		wb(1'b1, 8'h0c, 32'h23);
		wb(1'b1, 8'h04, 32'h6);
		wb(1'b1, 8'h00, 32'h10);
		rc(8'h08, 32'h3400, 32'h1400);
		rc(8'h4c, '1, 32'h10);
		// unknown method, bad block method, block without closed loop; a present
		// position reference between them must clear the refusal again
		op_en <= 1'b1;
		foreach (bad[i])
		begin
			wb(1'b1, 8'h00, 32'h0);
			wb(1'b1, 8'h0c, {24'h0, bad[i]});
			wb(1'b1, 8'h00, 32'h10);
			rc(8'h08, 32'h10000, {15'h0, bad[i] != 8'h23, 16'h0});
		end
		// the same block method starts once the loop is closed
		cl <= 1'b1;
		wb(1'b1, 8'h00, 32'h0);
		wb(1'b1, 8'h00, 32'h10);
		rc(8'h08, 32'h13400, 32'h0);
		cl <= 1'b0;
		wb(1'b1, 8'h14, 32'h4);
		wb(1'b1, 8'h18, 32'h2);
		wb(1'b1, 8'h1c, 32'h10);
		wb(1'b1, 8'h00, 32'h0);
		wb(1'b1, 8'h0c, 32'h1);
		wb(1'b1, 8'h00, 32'h10);
		rc(8'h08, 32'h13400, 32'h0);
		wt(10);
		rc(8'h08, 32'h3400, 32'h1400);
		wb(1'b1, 8'h00, 32'h0);
		wb(1'b1, 8'h00, 32'h10);
		wb(1'b1, 8'h00, 32'h0);
		rc(8'h08, 32'h3400, 32'h0400);
		// interpolate 32 counts ahead
		nmt <= 1'b1;
		wb(1'b0, 8'h4c, 32'h0);
		t = rd + 32'h20;
		wb(1'b1, 8'h2c, 32'h1);
		wb(1'b1, 8'h30, t);
		wb(1'b1, 8'h34, 32'h8);
		wb(1'b1, 8'h54, 32'h8);
		wb(1'b1, 8'h04, 32'h7);
		wb(1'b1, 8'h00, 32'h10);
		wt(12);
		`CK(status_o[12], 1'b1)
		wt(10);
		rc(8'h50, '1, t);
		// closed loop: the shaft runs on past the held demand
		cl <= 1'b1;
		wt(13);
		rc(8'h08, 32'h2000, 32'h2000);
		// halt brakes on the profile deceleration, one tick is enough
		wb(1'b1, 8'h38, 32'h8);
		wb(1'b1, 8'h00, 32'h110);
		repeat (40) @(posedge clk_i);
		`CK(vel_cmd_o, 32'h0)
		rc(8'h08, 32'h1400, 32'h1400);
		close_out();
	end
endmodule : testbench
